/* sys_clk_select.sv */
/*
   System clock source selector with AXI4-Lite control registers.
   The four oscillator outputs arrive asynchronously and are sampled by clk,
   which must run well above twice the fastest oscillator; the generated
   clocks are registered copies at clk resolution.
*/
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sys_clk_select #(
   parameter int ADDR_W = 8,
   parameter logic [15:0] SU_FAST = clk_sel_pkg::XTAL_SU_FAST,
   parameter logic [15:0] SU_SLOW = clk_sel_pkg::XTAL_SU_SLOW
) (
   input wire logic clk, // 250 MHz clock
   input wire logic rst, // asynchronous reset
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [3:0] osc_in, // raw oscillator outputs
   input wire logic [1:0] fast_rc_cfg, // non-volatile frequency option
   output logic sys_clk_out, // selected system clock
   output logic wdt_clk_out, // watchdog clock
   output logic tb_clk_out, // time base clock
   output logic [1:0] fast_rc_freq_out, // configured fast RC frequency
   output logic [1:0] fast_rc_freq_select, // software frequency field
   output logic fast_rc_enable_out, // fast RC run
   output logic slow_xtal_enable, // slow crystal run
   output logic slow_xtal_speedup, // slow crystal speed-up mode
   output logic slow_xtal_pins_gpio // slow crystal pins freed for I/O
);
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic aw_hold_ff, w_hold_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic [7:0] w_data_ff;
   logic w_strb_ff;
   logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
   logic [1:0] nxt_bresp, nxt_rresp;
   logic [31:0] nxt_rdata;
   logic nxt_aw_hold, nxt_w_hold;
   logic [ADDR_W-1:0] nxt_aw_addr;
   logic [7:0] nxt_w_data;
   logic nxt_w_strb;
   logic wr_fire, rd_fire;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [2:0] cks_ff, nxt_cks;
   logic hsel_ff, lsel_ff, hidle_ff, lidle_ff;
   logic nxt_hsel, nxt_lsel, nxt_hidle, nxt_lidle;
   logic [1:0] frc_sel_ff, nxt_frc_sel;
   logic frc_en_ff, nxt_frc_en;
   logic sx_en_ff, sx_sp_ff, pin_req_ff;
   logic nxt_sx_en, nxt_sx_sp, nxt_pin_req;
   logic sx_locked;
   logic [3:0] osc_meta_ff, osc_sync_ff, osc_prev_ff;
   logic [1:0] cfg_meta_ff, cfg_sync_ff, cfg_ff, nxt_cfg;
   logic cfg_done_ff, nxt_cfg_done;
   logic [1:0] cfg_age_ff, nxt_cfg_age;
   logic [15:0] su_cnt_ff, nxt_su_cnt;
   logic sx_ready_ff, nxt_sx_ready;
   logic [15:0] su_limit;
   logic pin_gpio_ff, nxt_pin_gpio;
   clk_sel_pkg::sw_state_e sw_ff, nxt_sw;
   logic [2:0] act_cks_ff, nxt_act_cks;
   logic act_hsel_ff, act_lsel_ff, nxt_act_hsel, nxt_act_lsel;
   logic [5:0] div_ff, nxt_div;
   logic fh, fh_prev, fsub, cand;
   logic sys_ff, nxt_sys, wdt_ff, tb_ff;

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign sys_clk_out = sys_ff;
   assign wdt_clk_out = wdt_ff;
   assign tb_clk_out = tb_ff;
   assign fast_rc_freq_out = cfg_ff;
   assign fast_rc_freq_select = frc_sel_ff;
   assign fast_rc_enable_out = frc_en_ff;
   assign slow_xtal_enable = sx_en_ff;
   assign slow_xtal_speedup = sx_sp_ff;
   assign slow_xtal_pins_gpio = pin_gpio_ff;

   // Bus slave: address and data are held until both are present.
   always_comb
   begin
      nxt_aw_hold = aw_hold_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_hold = w_hold_ff;
      nxt_w_data = w_data_ff;
      nxt_w_strb = w_strb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
      rd_fire = s_axi_arvalid && arready_ff;
      if (s_axi_awvalid && awready_ff)
      begin
         nxt_aw_hold = 1'b1;
         nxt_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff)
      begin
         nxt_w_hold = 1'b1;
         nxt_w_data = s_axi_wdata[7:0];
         nxt_w_strb = s_axi_wstrb[0];
      end
      if (bvalid_ff && s_axi_bready)
      begin
         nxt_bvalid = 1'b0;
      end
      if (wr_fire)
      begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = (aw_addr_ff > clk_sel_pkg::CLK_STATUS_OFS || aw_addr_ff[1:0] != 2'h0)
            ? clk_sel_pkg::RESP_SLVERR : clk_sel_pkg::RESP_OKAY;
      end
      rd_hit = 1'b1;
      case (s_axi_araddr)
         clk_sel_pkg::SYS_CLK_CTRL_OFS:
            rd_byte = {cks_ff, 1'b0, hsel_ff, lsel_ff, hidle_ff, lidle_ff};
         clk_sel_pkg::FAST_RC_CTRL_OFS:
            rd_byte = {4'h0, frc_sel_ff, frc_en_ff, frc_en_ff};
         clk_sel_pkg::SLOW_XTAL_CTRL_OFS:
            rd_byte = {5'h00, sx_sp_ff, sx_ready_ff, sx_en_ff};
         clk_sel_pkg::PIN_SHARE_OFS:
            rd_byte = {7'h00, pin_req_ff};
         clk_sel_pkg::CLK_STATUS_OFS:
            rd_byte = {act_cks_ff, sw_ff != clk_sel_pkg::SW_RUN, act_hsel_ff, act_lsel_ff,
               frc_sel_ff != cfg_ff, sx_ready_ff};
         default:
         begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
      if (rvalid_ff && s_axi_rready)
      begin
         nxt_rvalid = 1'b0;
      end
      if (rd_fire)
      begin
         nxt_rvalid = 1'b1;
         nxt_rdata = {24'h000000, rd_byte};
         nxt_rresp = rd_hit ? clk_sel_pkg::RESP_OKAY : clk_sel_pkg::RESP_SLVERR;
      end
      nxt_awready = !nxt_aw_hold && !nxt_bvalid;
      nxt_wready = !nxt_w_hold && !nxt_bvalid;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         arready_ff <= 1'b0;
         aw_hold_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_hold_ff <= 1'b0;
         w_data_ff <= 8'h00;
         w_strb_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'h0;
         rvalid_ff <= 1'b0;
         rresp_ff <= 2'h0;
         rdata_ff <= 32'h00000000;
      end
      else
      begin
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         arready_ff <= nxt_arready;
         aw_hold_ff <= nxt_aw_hold;
         aw_addr_ff <= nxt_aw_addr;
         w_hold_ff <= nxt_w_hold;
         w_data_ff <= nxt_w_data;
         w_strb_ff <= nxt_w_strb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
      end
   end

   // Control registers, slow crystal start-up and pin sharing.
   always_comb
   begin
      nxt_cks = cks_ff;
      nxt_hsel = hsel_ff;
      nxt_lsel = lsel_ff;
      nxt_hidle = hidle_ff;
      nxt_lidle = lidle_ff;
      nxt_frc_sel = frc_sel_ff;
      nxt_frc_en = frc_en_ff;
      nxt_sx_en = sx_en_ff;
      nxt_sx_sp = sx_sp_ff;
      nxt_pin_req = pin_req_ff;
      sx_locked = cks_ff == clk_sel_pkg::CKS_SLOW && lsel_ff;
      if (wr_fire && w_strb_ff)
      begin
         case (aw_addr_ff)
            clk_sel_pkg::SYS_CLK_CTRL_OFS:
            begin
               nxt_cks = w_data_ff[clk_sel_pkg::CKS_LSB +: 3];
               nxt_hsel = w_data_ff[clk_sel_pkg::HSEL_BIT];
               nxt_lsel = w_data_ff[clk_sel_pkg::LSEL_BIT];
               nxt_hidle = w_data_ff[clk_sel_pkg::HIDLE_BIT];
               nxt_lidle = w_data_ff[clk_sel_pkg::LIDLE_BIT];
            end
            clk_sel_pkg::FAST_RC_CTRL_OFS:
            begin
               nxt_frc_sel = w_data_ff[clk_sel_pkg::FRC_FREQ_LSB +: 2];
               nxt_frc_en = w_data_ff[clk_sel_pkg::FRC_EN_BIT];
            end
            clk_sel_pkg::SLOW_XTAL_CTRL_OFS:
            begin
               nxt_sx_en = w_data_ff[clk_sel_pkg::SX_EN_BIT];
               if (!sx_locked)
               begin
                  nxt_sx_sp = w_data_ff[clk_sel_pkg::SX_SPEEDUP_BIT];
               end
            end
            clk_sel_pkg::PIN_SHARE_OFS:
               nxt_pin_req = w_data_ff[clk_sel_pkg::PIN_GPIO_BIT];
            default:
               nxt_pin_req = pin_req_ff;
         endcase
      end
      // Low power mode only stretches the wait; the oscillator runs either way.
      su_limit = sx_sp_ff ? SU_FAST : SU_SLOW;
      nxt_su_cnt = su_cnt_ff;
      nxt_sx_ready = sx_ready_ff;
      if (!sx_en_ff)
      begin
         nxt_su_cnt = 16'h0000;
         nxt_sx_ready = 1'b0;
      end
      else if (!sx_ready_ff && osc_sync_ff[clk_sel_pkg::OSC_SLOW_XTAL]
         && !osc_prev_ff[clk_sel_pkg::OSC_SLOW_XTAL])
      begin
         nxt_su_cnt = su_cnt_ff + 16'h0001;
         nxt_sx_ready = nxt_su_cnt >= su_limit;
      end
      nxt_pin_gpio = pin_req_ff && !sx_en_ff && !lsel_ff;
      nxt_cfg = cfg_done_ff ? cfg_ff : cfg_sync_ff;
      // Reset clears the synchroniser, so the option is frozen only once it has passed both stages.
      nxt_cfg_age = (cfg_age_ff == 2'h2) ? cfg_age_ff : cfg_age_ff + 2'h1;
      nxt_cfg_done = cfg_done_ff || cfg_age_ff == 2'h2;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cks_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::CKS_LSB +: 3];
         hsel_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::HSEL_BIT];
         lsel_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::LSEL_BIT];
         hidle_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::HIDLE_BIT];
         lidle_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::LIDLE_BIT];
         frc_sel_ff <= clk_sel_pkg::FRC_FREQ_RST;
         frc_en_ff <= clk_sel_pkg::FRC_EN_RST;
         sx_en_ff <= 1'b0;
         sx_sp_ff <= 1'b0;
         pin_req_ff <= 1'b0;
         su_cnt_ff <= 16'h0000;
         sx_ready_ff <= 1'b0;
         pin_gpio_ff <= 1'b0;
         osc_meta_ff <= 4'h0;
         osc_sync_ff <= 4'h0;
         osc_prev_ff <= 4'h0;
         cfg_meta_ff <= 2'h0;
         cfg_sync_ff <= 2'h0;
         cfg_ff <= 2'h0;
         cfg_done_ff <= 1'b0;
         cfg_age_ff <= 2'h0;
      end
      else
      begin
         cks_ff <= nxt_cks;
         hsel_ff <= nxt_hsel;
         lsel_ff <= nxt_lsel;
         hidle_ff <= nxt_hidle;
         lidle_ff <= nxt_lidle;
         frc_sel_ff <= nxt_frc_sel;
         frc_en_ff <= nxt_frc_en;
         sx_en_ff <= nxt_sx_en;
         sx_sp_ff <= nxt_sx_sp;
         pin_req_ff <= nxt_pin_req;
         su_cnt_ff <= nxt_su_cnt;
         sx_ready_ff <= nxt_sx_ready;
         pin_gpio_ff <= nxt_pin_gpio;
         osc_meta_ff <= osc_in;
         osc_sync_ff <= osc_meta_ff;
         osc_prev_ff <= osc_sync_ff;
         cfg_meta_ff <= fast_rc_cfg;
         cfg_sync_ff <= cfg_meta_ff;
         cfg_ff <= nxt_cfg;
         cfg_done_ff <= nxt_cfg_done;
         cfg_age_ff <= nxt_cfg_age;
      end
   end

   // Clock path: the output is parked low between the old and new source.
   always_comb
   begin
      fh = act_hsel_ff ? osc_sync_ff[clk_sel_pkg::OSC_FAST_XTAL]
         : osc_sync_ff[clk_sel_pkg::OSC_FAST_RC];
      fh_prev = act_hsel_ff ? osc_prev_ff[clk_sel_pkg::OSC_FAST_XTAL]
         : osc_prev_ff[clk_sel_pkg::OSC_FAST_RC];
      fsub = act_lsel_ff ? osc_sync_ff[clk_sel_pkg::OSC_SLOW_XTAL]
         : osc_sync_ff[clk_sel_pkg::OSC_SLOW_RC];
      nxt_div = (fh && !fh_prev) ? div_ff + 6'h01 : div_ff;
      case (act_cks_ff)
         clk_sel_pkg::CKS_DIV1: cand = fh;
         clk_sel_pkg::CKS_SLOW: cand = fsub;
         default: cand = div_ff[3'(act_cks_ff - 3'h1)];
      endcase
      nxt_sw = sw_ff;
      nxt_act_cks = act_cks_ff;
      nxt_act_hsel = act_hsel_ff;
      nxt_act_lsel = act_lsel_ff;
      case (sw_ff)
         clk_sel_pkg::SW_RUN:
            if ({cks_ff, hsel_ff, lsel_ff} != {act_cks_ff, act_hsel_ff, act_lsel_ff})
            begin
               nxt_sw = clk_sel_pkg::SW_DRAIN;
            end
         clk_sel_pkg::SW_DRAIN:
            // Waiting for a low phase keeps the last high pulse full width.
            if (!cand)
            begin
               nxt_sw = clk_sel_pkg::SW_PARK;
               nxt_act_cks = cks_ff;
               nxt_act_hsel = hsel_ff;
               nxt_act_lsel = lsel_ff;
            end
         clk_sel_pkg::SW_PARK:
            if (!cand)
            begin
               nxt_sw = clk_sel_pkg::SW_RUN;
            end
         default:
            nxt_sw = clk_sel_pkg::SW_RUN;
      endcase
      nxt_sys = (sw_ff == clk_sel_pkg::SW_PARK) ? 1'b0 : cand;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sw_ff <= clk_sel_pkg::SW_RUN;
         act_cks_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::CKS_LSB +: 3];
         act_hsel_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::HSEL_BIT];
         act_lsel_ff <= clk_sel_pkg::SYS_CLK_CTRL_RST[clk_sel_pkg::LSEL_BIT];
         div_ff <= 6'h00;
         sys_ff <= 1'b0;
         wdt_ff <= 1'b0;
         tb_ff <= 1'b0;
      end
      else
      begin
         sw_ff <= nxt_sw;
         act_cks_ff <= nxt_act_cks;
         act_hsel_ff <= nxt_act_hsel;
         act_lsel_ff <= nxt_act_lsel;
         div_ff <= nxt_div;
         sys_ff <= nxt_sys;
         wdt_ff <= osc_sync_ff[clk_sel_pkg::OSC_SLOW_RC];
         tb_ff <= fsub;
      end
   end

   park_low_a: assert property (@(posedge clk) disable iff (rst)
      sw_ff == clk_sel_pkg::SW_PARK |=> !sys_ff)
      else $error("system clock not parked low during switch");
   drain_exit_a: assert property (@(posedge clk) disable iff (rst)
      sw_ff == clk_sel_pkg::SW_DRAIN && !cand |=> sw_ff == clk_sel_pkg::SW_PARK)
      else $error("switch did not park on low phase");
   mode_lock_a: assert property (@(posedge clk) disable iff (rst)
      sx_locked && wr_fire |=> $stable(sx_sp_ff))
      else $error("slow crystal mode changed while locked");
   xtal_stop_a: assert property (@(posedge clk) disable iff (rst)
      !sx_en_ff |=> !sx_ready_ff)
      else $error("slow crystal ready while disabled");
   slow_src_a: assert property (@(posedge clk) disable iff (rst)
      sw_ff == clk_sel_pkg::SW_RUN && act_cks_ff == clk_sel_pkg::CKS_SLOW && !act_lsel_ff
      |=> sys_ff == $past(osc_sync_ff[clk_sel_pkg::OSC_SLOW_RC]))
      else $error("slow RC not routed to system clock");
   fast_src_a: assert property (@(posedge clk) disable iff (rst)
      sw_ff == clk_sel_pkg::SW_RUN && act_cks_ff == clk_sel_pkg::CKS_DIV1 && act_hsel_ff
      |=> sys_ff == $past(osc_sync_ff[clk_sel_pkg::OSC_FAST_XTAL]))
      else $error("fast crystal not routed to system clock");
   pin_free_a: assert property (@(posedge clk) disable iff (rst)
      sx_en_ff |=> !pin_gpio_ff)
      else $error("crystal pins freed while crystal enabled");
   cfg_hold_a: assert property (@(posedge clk) disable iff (rst)
      cfg_done_ff |=> $stable(cfg_ff))
      else $error("fast RC option changed at run time");
   wdt_route_a: assert property (@(posedge clk) disable iff (rst)
      ##1 1'b1 |-> wdt_ff == $past(osc_sync_ff[clk_sel_pkg::OSC_SLOW_RC]))
      else $error("watchdog clock not from slow RC");
endmodule

/* clk_sel_pkg.sv */
/*
   Constants for the system clock source selector: register map, field
   positions, reset values, switch states and crystal start-up counts.
   Assumes a 32-bit AXI4-Lite register bus and byte addresses.
*/
package clk_sel_pkg;
   localparam logic [7:0] SYS_CLK_CTRL_OFS = 8'h00;
   localparam logic [7:0] FAST_RC_CTRL_OFS = 8'h04;
   localparam logic [7:0] SLOW_XTAL_CTRL_OFS = 8'h08;
   localparam logic [7:0] PIN_SHARE_OFS = 8'h0C;
   localparam logic [7:0] CLK_STATUS_OFS = 8'h10;
   localparam int CKS_LSB = 5;
   localparam int HSEL_BIT = 3;
   localparam int LSEL_BIT = 2;
   localparam int HIDLE_BIT = 1;
   localparam int LIDLE_BIT = 0;
   localparam int FRC_FREQ_LSB = 2;
   localparam int FRC_STABLE_BIT = 1;
   localparam int FRC_EN_BIT = 0;
   localparam int SX_SPEEDUP_BIT = 2;
   localparam int SX_READY_BIT = 1;
   localparam int SX_EN_BIT = 0;
   localparam int PIN_GPIO_BIT = 0;
   localparam int ST_BUSY_BIT = 4;
   localparam int ST_MISMATCH_BIT = 1;
   localparam int ST_SX_READY_BIT = 0;
   localparam logic [2:0] CKS_SLOW = 3'h7;
   localparam logic [2:0] CKS_DIV1 = 3'h0;
   localparam logic [7:0] SYS_CLK_CTRL_RST = 8'h00;
   localparam logic [1:0] FRC_FREQ_RST = 2'h0;
   localparam logic FRC_EN_RST = 1'b1;
   localparam int OSC_FAST_RC = 0;
   localparam int OSC_FAST_XTAL = 1;
   localparam int OSC_SLOW_RC = 2;
   localparam int OSC_SLOW_XTAL = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [15:0] XTAL_SU_FAST = 16'h0400;
   localparam logic [15:0] XTAL_SU_SLOW = 16'h2000;
   typedef enum logic [1:0] {SW_RUN = 2'h0, SW_DRAIN = 2'h1, SW_PARK = 2'h3} sw_state_e;
endpackage

/* osc_model.sv */
/*
   Model of the four oscillators that feed the clock selector.
   Assumes a 4 ns sampling clock. The periods are scaled down and kept at
   multiples of that clock, so that sampled periods come out exact.
*/
`timescale 1ns/1ps
module osc_model (
   input wire logic xtal_run, // slow crystal enable
   output logic [3:0] osc // oscillator outputs
);
   initial osc = 4'h0;
   always #20 osc[0] = ~osc[0];
   always #28 osc[1] = ~osc[1];
   always #100 osc[2] = ~osc[2];
   // The crystal swings in either mode while enabled and rests low otherwise.
   always #120 osc[3] = xtal_run ? ~osc[3] : 1'h0;
endmodule

/* system_clock_source_select_bench.sv */
/*
   Self-checking bench for the system clock selector.
   Assumes the oscillator model drives the four sources at scaled periods.
*/
`timescale 1ns/1ps
module system_clock_source_select_bench;
   localparam logic [7:0] CTRL_A = clk_sel_pkg::SYS_CLK_CTRL_OFS;
   localparam logic [7:0] FRC_A = clk_sel_pkg::FAST_RC_CTRL_OFS;
   localparam logic [7:0] SX_A = clk_sel_pkg::SLOW_XTAL_CTRL_OFS;
   localparam logic [7:0] PIN_A = clk_sel_pkg::PIN_SHARE_OFS;
   localparam logic [7:0] STAT_A = clk_sel_pkg::CLK_STATUS_OFS;
   localparam logic [1:0] OK = clk_sel_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = clk_sel_pkg::RESP_SLVERR;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, sys_clk, wdt_clk, tb_clk, en, sp, gpio, fen;
   logic [1:0] bresp, rresp, cfg_out, frc_sel;
   logic [1:0] cfg = 2'h2;
   logic [31:0] rdata;
   logic [3:0] osc;
   logic [2:0] clks;
   int num_errors = 0, n_checks = 0, cyc = 0;
   assign clks = {tb_clk, wdt_clk, sys_clk};
   always #2 clk = ~clk;
   osc_model oscs (.xtal_run(en), .osc(osc));
   sys_clk_select #(.SU_FAST(16'h0004), .SU_SLOW(16'h0008)) dut (.clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .osc_in(osc), .fast_rc_cfg(cfg), .sys_clk_out(sys_clk), .wdt_clk_out(wdt_clk),
      .tb_clk_out(tb_clk), .fast_rc_freq_out(cfg_out), .fast_rc_freq_select(frc_sel),
      .fast_rc_enable_out(fen), .slow_xtal_enable(en), .slow_xtal_speedup(sp),
      .slow_xtal_pins_gpio(gpio));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Handshakes are judged at the falling edge, so that the release at the next
   // rising edge never races the slave's own register updates.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
      logic ta, tw, tb, tr, td;
      @(posedge clk);
      if (w)
      begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
      end
      else
      begin
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
      end
      forever
      begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bready && bvalid;
         tr = arvalid && arready;
         td = rready && rvalid;
         r = tb ? bresp : rresp;
         q = rdata;
         @(posedge clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tr) arvalid <= 1'h0;
         if (tb) bready <= 1'h0;
         if (td) rready <= 1'h0;
         if (tb || td) return;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'h1, a, d, q, r);
      chk(r, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'h0, a, 32'h0, q, r);
      chk(q, e);
      chk(r, er);
   endtask
   task automatic lvl(input int k, input logic v, inout int c);
      while (clks[k] !== v && c < 3000)
      begin
         @(negedge clk);
         c++;
      end
   endtask
   // Lets a switch settle, then counts clk cycles from one rising edge to the next.
   task automatic per(input int k, input int e);
      int c = 0;
      repeat (3 * e + 200) @(negedge clk);
      lvl(k, 1'h0, c);
      lvl(k, 1'h1, c);
      c = 0;
      lvl(k, 1'h0, c);
      lvl(k, 1'h1, c);
      chk(c, e);
   endtask
   task automatic t_reset();
      rd(CTRL_A, 32'h0, OK);
      rd(FRC_A, 32'h3, OK);
      rd(SX_A, 32'h0, OK);
      rd(8'h20, 32'h0, ERR);
      wr(8'h20, 32'hFF, ERR);
      chk(fen, 1'h1);
      chk(cfg_out, 2'h2);
      rd(STAT_A, 32'h2, OK);
      wr(FRC_A, 32'h9, OK);
      @(negedge clk);
      chk(frc_sel, 2'h2);
      $display("reset and fast RC test done");
   endtask
   task automatic t_divide();
      for (int n = 0; n < 7; n++)
      begin
         wr(CTRL_A, n << 5, OK);
         per(0, 10 << n);
      end
      $display("divide test done");
   endtask
   task automatic t_sources();
      wr(CTRL_A, 32'h08, OK);
      per(0, 14);
      wr(CTRL_A, 32'hE0, OK);
      per(0, 50);
      per(1, 50);
      per(2, 50);
      $display("source test done");
   endtask
   task automatic t_xtal();
      wr(SX_A, 32'h01, OK);
      chk(en, 1'h1);
      repeat (300) @(negedge clk);
      rd(SX_A, 32'h01, OK);
      repeat (300) @(negedge clk);
      rd(SX_A, 32'h03, OK);
      wr(SX_A, 32'h00, OK);
      wr(SX_A, 32'h05, OK);
      repeat (300) @(negedge clk);
      rd(SX_A, 32'h07, OK);
      wr(SX_A, 32'h01, OK);
      rd(SX_A, 32'h03, OK);
      wr(CTRL_A, 32'hE4, OK);
      per(0, 60);
      per(2, 60);
      wr(SX_A, 32'h05, OK);
      rd(SX_A, 32'h03, OK);
      chk(sp, 1'h0);
      $display("slow crystal test done");
   endtask
   task automatic t_pins();
      wr(PIN_A, 32'h1, OK);
      @(negedge clk);
      chk(gpio, 1'h0);
      wr(CTRL_A, 32'h00, OK);
      wr(SX_A, 32'h00, OK);
      repeat (2) @(negedge clk);
      chk(gpio, 1'h1);
      $display("pin share test done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         num_errors++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
      t_reset();
      t_divide();
      t_sources();
      t_xtal();
      t_pins();
      report_and_stop();
   end
endmodule
